// ---- rtl/mash_top.sv ----
// stage configuration store, host link setup and homing sequencer with ahb-lite registers
// Operation
// - all settings live in a store and directly drive the operating logic
// - one host interface chosen by setting; serial after reset
// - handshake setting on gives rts/cts pacing, off gives none; default on
// - five serial rates 4800 to 57600, default 38400
// - per-axis microstep divide from fixed legal list, default 20
// - per-axis travel per full step 1..1000 x0.1um, default 20, converts distance
// - per-axis direction setting flips motor rotation, default positive
// - per-axis homing method 0..6, 0 disables, default 1
// - homing offset in 0.01um used only by methods 1, 5 and 6
// - programmed offset zero means 0.5 mm offset
// - estop keeps or drops excitation per axis setting, default keep
// - method 0 performs no homing motion
// - method 1 legacy homing then moves on to offset
// - methods 3,4 use limit/near/home sensors; 5,6 use z phase as origin
// - methods 3,4 reverse at one limit, stop at other without origin
// - method 4 after near-home moves cw, stops at cw limit without origin
//
// Decided for this implementation: the AHB-Lite register port and the address map.
`timescale 1ns/100ps
module mash_top
  import mash_pkg::*;
(
  // clock and reset
  input  wire logic        SYS_CLK,
  input  wire logic        RST,
  // ahb-lite slave
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  // interrupt
  output logic             IRQ,
  // sensor and estop pins
  input  wire logic [7:0]  LIMIT_CW,
  input  wire logic [7:0]  LIMIT_CCW,
  input  wire logic [7:0]  NEAR_HOME,
  input  wire logic [7:0]  HOME,
  input  wire logic [7:0]  ZPHASE,
  input  wire logic        ESTOP,
  // motor drive
  output logic      [7:0]  MOT_STEP,
  output logic      [7:0]  MOT_DIR,
  output logic      [7:0]  MOT_EXCITE,
  // host link selection and serial pacing
  output logic             IF_SERIAL_EN,
  output logic             IF_USB_EN,
  output logic             IF_ETH_EN,
  output logic             BAUD_TICK,
  input  wire logic        SER_CTS_N,
  input  wire logic        RX_SPACE,
  output logic             SER_RTS_N,
  output logic             TX_PERMIT
);

  typedef enum {H_IDLE, H_SEEK, H_CREEP, H_OFFSET} mash_hstate_t;

  mash_global_cfg_t gcfg;
  mash_axis_cfg_t   acfg [AXES];
  mash_sensor_t     sens_meta;
  mash_sensor_t     sens;
  logic             estop_meta;
  logic             estop_s;
  logic             cts_n_meta;
  logic             cts_n_s;
  logic             estop_q;
  logic [EV_W-1:0]  irq_stat;
  logic [EV_W-1:0]  irq_mask;
  logic [EV_W-1:0]  ev;
  logic [7:0]       homed;
  // bus data phase
  logic             dp_write;
  logic [7:0]       dp_addr;
  logic             wr_en;
  logic [31:0]      next_rdata;
  // homing sequencer
  mash_hstate_t     hstate;
  logic [2:0]       h_axis;
  logic             h_cw;
  logic             h_reversed;
  logic [37:0]      h_acc;
  logic [37:0]      h_target;
  logic [15:0]      step_cnt;
  logic             step_tick;
  logic [13:0]      baud_cnt;
  logic [13:0]      baud_div;
  logic             cmd_start;
  logic             cmd_abort;
  logic             cmd_defaults;
  logic [2:0]       cmd_axis;
  logic             origin_seen;
  logic             limit_ahead;
  logic             fail_now;
  logic             done_now;

  // legal microstep divisions
  function automatic logic divide_ok(input logic [7:0] d);
    case (d)
      8'h01, 8'h02, 8'h04, 8'h05, 8'h08, 8'h0a, 8'h14, 8'h19, 8'h28, 8'h32, 8'h50,
      8'h64, 8'h7d, 8'hc8, 8'hfa: divide_ok = 1'b1;
      default: divide_ok = 1'b0;
    endcase
  endfunction

  // two-flop synchronisers on the sensor, estop and cts pins; RX_SPACE is used unsynchronised
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      sens_meta  <= '0;
      sens       <= '0;
      estop_meta <= 1'b0;
      estop_s    <= 1'b0;
      cts_n_meta <= 1'b1; // withdrawn until the pin is seen
      cts_n_s    <= 1'b1;
    end else begin
      sens_meta  <= {LIMIT_CW, LIMIT_CCW, NEAR_HOME, HOME, ZPHASE};
      sens       <= sens_meta;
      estop_meta <= ESTOP;
      estop_s    <= estop_meta;
      cts_n_meta <= SER_CTS_N;
      cts_n_s    <= cts_n_meta;
    end
  end

  // zero-wait slave: address phase captured, data phase acts
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      dp_write <= 1'b0;
      dp_addr  <= 8'h00;
      HRDATA   <= 32'h0000_0000;
    end else begin
      dp_write <= 1'b0;
      if (HSEL && HTRANS[1] && HREADY) begin
        dp_write <= HWRITE;
        dp_addr  <= HADDR[7:0];
        if (!HWRITE) begin
          HRDATA <= next_rdata;
        end
      end
    end
  end

  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;
  assign wr_en     = dp_write;

  // read mux; unmapped words read zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (HADDR[7:0])
      REG_GLOBAL:   next_rdata = {26'h0, gcfg};
      REG_STATUS:   next_rdata = {13'h0, estop_s, homed, 3'h0, h_axis, 3'h0,
                                  (hstate != H_IDLE)};
      REG_IRQ_STAT: next_rdata = {29'h0, irq_stat};
      REG_IRQ_MASK: next_rdata = {29'h0, irq_mask};
      default: begin
        if (HADDR[7:6] == 2'b01) begin
          if (HADDR[2]) begin
            next_rdata = {2'h0, acfg[HADDR[5:3]].homing_offset};
          end else begin
            next_rdata = {9'h0, acfg[HADDR[5:3]].estop_hold_excitation,
                          acfg[HADDR[5:3]].homing_method_select,
                          acfg[HADDR[5:3]].dir_negative, acfg[HADDR[5:3]].base_rate,
                          acfg[HADDR[5:3]].divide};
          end
        end
      end
    endcase
  end

  // control word decode, acts for one cycle only
  always_comb begin
    cmd_start    = wr_en && (dp_addr == REG_CONTROL) && HWDATA[3];
    cmd_abort    = wr_en && (dp_addr == REG_CONTROL) && HWDATA[4];
    cmd_defaults = wr_en && (dp_addr == REG_CONTROL) && HWDATA[5];
    cmd_axis     = HWDATA[2:0];
  end

  // global settings store; illegal codes leave the old value
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      gcfg <= '{RST_IFACE, RST_HSHAKE, RST_BAUD};
    end else if (cmd_defaults) begin
      gcfg <= '{RST_IFACE, RST_HSHAKE, RST_BAUD};
    end else if (wr_en && dp_addr == REG_GLOBAL) begin
      if (HWDATA[5:4] != 2'h3) begin
        gcfg.iface <= HWDATA[5:4];
      end
      gcfg.serial_handshake_enable <= HWDATA[3];
      if (HWDATA[2:0] <= 3'h4) begin
        gcfg.baud_sel <= HWDATA[2:0];
      end
    end
  end

  // per-axis settings store, one copy per axis
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      for (int i = 0; i < AXES; i++) begin
        acfg[i] <= '{RST_DIVIDE, RST_BASE, 1'b0, RST_METHOD, 1'b1, 30'h0};
      end
    end else if (cmd_defaults) begin
      for (int i = 0; i < AXES; i++) begin
        acfg[i] <= '{RST_DIVIDE, RST_BASE, 1'b0, RST_METHOD, 1'b1, 30'h0};
      end
    end else if (wr_en && dp_addr[7:6] == 2'b01) begin
      if (dp_addr[2]) begin
        if (HWDATA[29:0] <= OFFSET_MAX) begin
          acfg[dp_addr[5:3]].homing_offset <= HWDATA[29:0];
        end
      end else begin
        if (divide_ok(HWDATA[7:0])) begin
          acfg[dp_addr[5:3]].divide <= HWDATA[7:0];
        end
        if (HWDATA[17:8] != 10'h000 && HWDATA[17:8] <= BASE_MAX) begin
          acfg[dp_addr[5:3]].base_rate <= HWDATA[17:8];
        end
        acfg[dp_addr[5:3]].dir_negative <= HWDATA[18];
        if (HWDATA[21:19] <= HOMING_METHOD_ZPHASE_B) begin
          acfg[dp_addr[5:3]].homing_method_select <= HWDATA[21:19];
        end
        acfg[dp_addr[5:3]].estop_hold_excitation <= HWDATA[22];
      end
    end
  end

  // host link selection outputs follow the stored setting
  assign IF_SERIAL_EN = (gcfg.iface == IF_SERIAL);
  assign IF_USB_EN    = (gcfg.iface == IF_USB);
  assign IF_ETH_EN    = (gcfg.iface == IF_ETHERNET);

  // with handshake on, rts asks for data only while receive room exists and cts gates sending; off, rts always asks
  assign SER_RTS_N = gcfg.serial_handshake_enable ? ~RX_SPACE : 1'b0;
  assign TX_PERMIT = IF_SERIAL_EN && (!gcfg.serial_handshake_enable || !cts_n_s);

  // bit-rate divider; rounding keeps every rate within 0.1 percent
  always_comb begin
    case (gcfg.baud_sel)
      3'h0:    baud_div = 14'(BAUD_DIV_0);
      3'h1:    baud_div = 14'(BAUD_DIV_1);
      3'h2:    baud_div = 14'(BAUD_DIV_2);
      3'h4:    baud_div = 14'(BAUD_DIV_4);
      default: baud_div = 14'(BAUD_DIV_3);
    endcase
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      baud_cnt  <= 14'h0000;
      BAUD_TICK <= 1'b0;
    end else if (baud_cnt >= baud_div - 14'h0001) begin
      baud_cnt  <= 14'h0000;
      BAUD_TICK <= IF_SERIAL_EN;
    end else begin
      baud_cnt  <= baud_cnt + 14'h0001;
      BAUD_TICK <= 1'b0;
    end
  end

  // homing step-rate enable
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      step_cnt  <= 16'h0000;
      step_tick <= 1'b0;
    end else if (step_cnt == 16'(STEP_DIV - 1)) begin
      step_cnt  <= 16'h0000;
      step_tick <= 1'b1;
    end else begin
      step_cnt  <= step_cnt + 16'h0001;
      step_tick <= 1'b0;
    end
  end

  // origin signal and limit in the travel direction for the active axis
  always_comb begin
    case (acfg[h_axis].homing_method_select)
      HOMING_METHOD_FOUR_SENSOR: origin_seen = sens.near_home[h_axis];
      HOMING_METHOD_ZPHASE_A,
      HOMING_METHOD_ZPHASE_B:    origin_seen = sens.zphase[h_axis];
      default:                   origin_seen = sens.home[h_axis];
    endcase
    limit_ahead = h_cw ? sens.limit_cw[h_axis] : sens.limit_ccw[h_axis];
  end

  // homing sequencer, one axis at a time; estop aborts motion
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      hstate     <= H_IDLE;
      h_axis     <= 3'h0;
      h_cw       <= 1'b1;
      h_reversed <= 1'b0;
      h_acc      <= 38'h0;
      h_target   <= 38'h0;
      MOT_STEP   <= 8'h00;
      fail_now   <= 1'b0;
      done_now   <= 1'b0;
    end else begin
      MOT_STEP <= 8'h00;
      fail_now <= 1'b0;
      done_now <= 1'b0;
      case (hstate)
        H_IDLE: begin
          if (cmd_start && !estop_s) begin
            h_axis     <= cmd_axis;
            h_reversed <= 1'b0;
            h_acc      <= 38'h0;
            // legacy and second z-phase method approach from the ccw side
            h_cw       <= !(acfg[cmd_axis].homing_method_select == HOMING_METHOD_LEGACY ||
                            acfg[cmd_axis].homing_method_select == HOMING_METHOD_ZPHASE_B);
            h_target   <= 38'(acfg[cmd_axis].homing_offset == 30'h0 ? OFFSET_ZERO :
                              acfg[cmd_axis].homing_offset) *
                          38'(acfg[cmd_axis].divide);
            if (acfg[cmd_axis].homing_method_select == HOMING_METHOD_NONE) begin
              done_now <= 1'b1;
            end else begin
              hstate <= H_SEEK;
            end
          end
        end
        H_SEEK: begin
          if (cmd_abort || estop_s) begin
            hstate   <= H_IDLE;
            fail_now <= 1'b1;
          end else if (step_tick) begin
            if (origin_seen) begin
              case (acfg[h_axis].homing_method_select)
                HOMING_METHOD_FOUR_SENSOR: begin
                  hstate <= H_CREEP;
                  h_cw   <= 1'b1;
                end
                HOMING_METHOD_LEGACY, HOMING_METHOD_ZPHASE_A, HOMING_METHOD_ZPHASE_B: begin
                  hstate <= H_OFFSET;
                  h_cw   <= 1'b1;
                end
                default: begin
                  hstate   <= H_IDLE;
                  done_now <= 1'b1;
                end
              endcase
            end else if (limit_ahead) begin
              if (!h_reversed) begin
                h_reversed <= 1'b1;
                h_cw       <= !h_cw;
              end else begin
                hstate   <= H_IDLE;
                fail_now <= 1'b1;
              end
            end else begin
              MOT_STEP[h_axis] <= 1'b1;
            end
          end
        end
        H_CREEP: begin
          if (cmd_abort || estop_s) begin
            hstate   <= H_IDLE;
            fail_now <= 1'b1;
          end else if (step_tick) begin
            if (sens.home[h_axis]) begin
              hstate   <= H_IDLE;
              done_now <= 1'b1;
            end else if (sens.limit_cw[h_axis]) begin
              hstate   <= H_IDLE;
              fail_now <= 1'b1;
            end else begin
              MOT_STEP[h_axis] <= 1'b1;
            end
          end
        end
        H_OFFSET: begin
          if (cmd_abort || estop_s) begin
            hstate   <= H_IDLE;
            fail_now <= 1'b1;
          end else if (step_tick) begin
            if (h_acc >= h_target) begin
              hstate   <= H_IDLE;
              done_now <= 1'b1;
            end else if (sens.limit_cw[h_axis]) begin
              hstate   <= H_IDLE;
              fail_now <= 1'b1;
            end else begin
              // each microstep covers base_rate*10/divide hundredths of a um
              MOT_STEP[h_axis] <= 1'b1;
              h_acc <= h_acc + 38'({acfg[h_axis].base_rate, 3'h0}) +
                       38'({acfg[h_axis].base_rate, 1'b0});
            end
          end
        end
        default: hstate <= H_IDLE;
      endcase
    end
  end

  // per-axis direction and winding excitation
  always_comb begin
    for (int i = 0; i < AXES; i++) begin
      MOT_DIR[i]    = ((h_axis == 3'(i)) ? h_cw : 1'b1) ^ acfg[i].dir_negative;
      MOT_EXCITE[i] = !estop_s || acfg[i].estop_hold_excitation;
    end
  end

  // homed flags: set when a method other than 0 completes, cleared when a start command for the axis arrives in idle
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      homed <= 8'h00;
    end else if (done_now) begin
      homed[h_axis] <= (acfg[h_axis].homing_method_select != HOMING_METHOD_NONE);
    end else if (cmd_start && hstate == H_IDLE) begin
      homed[cmd_axis] <= 1'b0;
    end
  end

  // estop rising edge
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      estop_q <= 1'b0;
    end else begin
      estop_q <= estop_s;
    end
  end

  assign ev = {estop_s && !estop_q, fail_now, done_now};

  // sticky events, write one to clear; a new event beats the clear
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      irq_stat <= '0;
      irq_mask <= '0;
    end else begin
      if (wr_en && dp_addr == REG_IRQ_STAT) begin
        irq_stat <= (irq_stat & ~HWDATA[EV_W-1:0]) | ev;
      end else begin
        irq_stat <= irq_stat | ev;
      end
      if (wr_en && dp_addr == REG_IRQ_MASK) begin
        irq_mask <= HWDATA[EV_W-1:0];
      end
    end
  end

  assign IRQ = |(irq_stat & irq_mask);

endmodule

// ---- shared/mash_pkg.sv ----
// shared constants, types and register map of the stage configuration and homing block
package mash_pkg;
  localparam int unsigned CLK_HZ       = 40_000_000;
  localparam int unsigned AXES         = 8;
  // host interface selection codes
  localparam logic [1:0]  IF_SERIAL    = 2'h0;
  localparam logic [1:0]  IF_USB       = 2'h1;
  localparam logic [1:0]  IF_ETHERNET  = 2'h2;
  // serial bit rates in bit/s, index 0..4, and their clock dividers
  localparam int unsigned BAUD_0       = 4800;
  localparam int unsigned BAUD_1       = 9600;
  localparam int unsigned BAUD_2       = 19200;
  localparam int unsigned BAUD_3       = 38400;
  localparam int unsigned BAUD_4       = 57600;
  localparam int unsigned BAUD_DIV_0   = (CLK_HZ + BAUD_0 / 2) / BAUD_0;
  localparam int unsigned BAUD_DIV_1   = (CLK_HZ + BAUD_1 / 2) / BAUD_1;
  localparam int unsigned BAUD_DIV_2   = (CLK_HZ + BAUD_2 / 2) / BAUD_2;
  localparam int unsigned BAUD_DIV_3   = (CLK_HZ + BAUD_3 / 2) / BAUD_3;
  localparam int unsigned BAUD_DIV_4   = (CLK_HZ + BAUD_4 / 2) / BAUD_4;
  // homing step rate
  localparam int unsigned STEP_HZ      = 100_000;
  localparam int unsigned STEP_DIV     = CLK_HZ / STEP_HZ;
  // reset values, setting limits and the zero-offset distance
  localparam logic [1:0]  RST_IFACE    = IF_SERIAL;
  localparam logic        RST_HSHAKE   = 1'b1;
  localparam logic [2:0]  RST_BAUD     = 3'h3;
  localparam logic [7:0]  RST_DIVIDE   = 8'h14;
  localparam logic [9:0]  RST_BASE     = 10'h014;
  localparam logic [9:0]  BASE_MAX     = 10'h3e8;
  localparam logic [2:0]  RST_METHOD   = 3'h1;
  localparam logic [29:0] OFFSET_MAX   = 30'h3b9ac9ff;
  localparam logic [29:0] OFFSET_ZERO  = 30'h0000c350; // 0.5 mm in 0.01 um
  // homing methods
  localparam logic [2:0]  HOMING_METHOD_NONE         = 3'h0;
  localparam logic [2:0]  HOMING_METHOD_LEGACY       = 3'h1;
  localparam logic [2:0]  HOMING_METHOD_THREE_SENSOR = 3'h3;
  localparam logic [2:0]  HOMING_METHOD_FOUR_SENSOR  = 3'h4;
  localparam logic [2:0]  HOMING_METHOD_ZPHASE_A     = 3'h5;
  localparam logic [2:0]  HOMING_METHOD_ZPHASE_B     = 3'h6;
  // register byte offsets
  localparam logic [7:0]  REG_GLOBAL   = 8'h00;
  localparam logic [7:0]  REG_CONTROL  = 8'h04;
  localparam logic [7:0]  REG_STATUS   = 8'h08;
  localparam logic [7:0]  REG_IRQ_STAT = 8'h0c;
  localparam logic [7:0]  REG_IRQ_MASK = 8'h10;
  localparam logic [7:0]  REG_AXIS     = 8'h40; // axis n at 0x40 + 8n, offset word +4
  // event bits
  localparam int unsigned EV_DONE      = 0;
  localparam int unsigned EV_FAIL      = 1;
  localparam int unsigned EV_ESTOP     = 2;
  localparam int unsigned EV_W         = 3;

  typedef struct packed {
    logic [7:0]  divide;
    logic [9:0]  base_rate;
    logic        dir_negative;
    logic [2:0]  homing_method_select;
    logic        estop_hold_excitation;
    logic [29:0] homing_offset;
  } mash_axis_cfg_t;

  typedef struct packed {
    logic [1:0]  iface;
    logic        serial_handshake_enable;
    logic [2:0]  baud_sel;
  } mash_global_cfg_t;

  typedef struct packed {
    logic [7:0]  limit_cw;
    logic [7:0]  limit_ccw;
    logic [7:0]  near_home;
    logic [7:0]  home;
    logic [7:0]  zphase;
  } mash_sensor_t;
endpackage

// ---- tb/mash_top_asserts.sv ----
// port checker for the stage configuration and homing block
`timescale 1ns/100ps
module mash_top_chk (
  // clock, reset and bus
  input wire logic        SYS_CLK,
  input wire logic        RST,
  input wire logic        HSEL,
  input wire logic [1:0]  HTRANS,
  input wire logic        HWRITE,
  input wire logic        HREADY,
  input wire logic [31:0] HRDATA,
  // motion and link pins
  input wire logic        ESTOP,
  input wire logic [7:0]  MOT_STEP,
  input wire logic [7:0]  MOT_EXCITE,
  input wire logic        IF_SERIAL_EN,
  input wire logic        IF_USB_EN,
  input wire logic        IF_ETH_EN,
  input wire logic        BAUD_TICK,
  input wire logic        TX_PERMIT
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  // read data only moves after a read address phase
  property p_rdata; !$past(HSEL && HTRANS[1] && HREADY && !HWRITE) |-> $stable(HRDATA); endproperty
  a_rdata: assert property (p_rdata) else $error("read data moved without a read");
  property p_iface; $onehot({IF_SERIAL_EN, IF_USB_EN, IF_ETH_EN}); endproperty
  a_iface: assert property (p_iface) else $error("host link select not one-hot");
  // tick is registered, so allow one cycle of lag after a switch
  property p_tick; BAUD_TICK |-> IF_SERIAL_EN || $past(IF_SERIAL_EN); endproperty
  a_tick: assert property (p_tick) else $error("bit tick without serial link");
  property p_tick_gap; BAUD_TICK |=> (!BAUD_TICK) [*8]; endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("bit ticks too close");
  property p_txp; TX_PERMIT |-> IF_SERIAL_EN; endproperty
  a_txp: assert property (p_txp) else $error("transmit permit off serial");
  property p_excite; (!ESTOP) [*3] |-> MOT_EXCITE == 8'hff; endproperty
  a_excite: assert property (p_excite) else $error("excitation dropped without estop");
  property p_estop_halt; ESTOP [*6] |-> MOT_STEP == 8'h00; endproperty
  a_estop_halt: assert property (p_estop_halt) else $error("steps during estop");
  property p_one_axis; $onehot0(MOT_STEP); endproperty
  a_one_axis: assert property (p_one_axis) else $error("steps on two axes");
  property p_step_gap; MOT_STEP != 8'h00 |=> (MOT_STEP == 8'h00) [*8]; endproperty
  a_step_gap: assert property (p_step_gap) else $error("step pulses too close");
endmodule

// ---- tb/mash_host_model.sv ----
// host end of the serial link: paces the device through cts and receiver room
`timescale 1ns/100ps
module mash_host_model (
  // pacing control from the bench
  input  wire logic busy_host,
  // link pins
  output logic      ser_cts_n,
  output logic      rx_space
);
  // a busy host withdraws cts and its receive room together
  assign ser_cts_n = busy_host;
  assign rx_space  = !busy_host;
endmodule

// ---- tb/mash_top_bench.sv ----
// self-checking bench: register table, reset values, link pacing, homing and estop
`timescale 1ns/100ps
module mash_top_bench;
  import mash_pkg::*;
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] e;} mash_row_t;
  logic         clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, estop = 1'b0;
  logic         busy_host = 1'b1;
  logic [1:0]   htrans = 2'h0;
  logic [31:0]  haddr = 32'h0, hwdata = 32'h0, hrdata, q;
  logic         hready, hresp, irq, tick, rts_n, cts_n, room, txp, ser, usb, eth;
  logic [7:0]   step, dir, exc;
  mash_sensor_t sens = '0;
  int           num_errors = 0, tests_run = 0, cyc = 0, n;
  int unsigned  divs [5] = '{BAUD_DIV_0, BAUD_DIV_1, BAUD_DIV_2, BAUD_DIV_3, BAUD_DIV_4};
  // write, readback
  mash_row_t rows [11] = '{
    '{8'h00, 32'h0000000a, 32'h0000000a}, '{8'h00, 32'h0000000d, 32'h0000000a},
    '{8'h00, 32'h0000001a, 32'h0000001a}, '{8'h00, 32'h0000003a, 32'h0000001a},
    '{8'h40, 32'h00480119, 32'h00480119}, '{8'h40, 32'h00480103, 32'h00480119},
    '{8'h48, 32'h004be914, 32'h00481414}, '{8'h50, 32'h00781414, 32'h00481414},
    '{8'h54, 32'h3b9aca00, 32'h00000000}, '{8'h44, 32'h3b9ac9ff, 32'h3b9ac9ff},
    '{8'h20, 32'hffffffff, 32'h00000000}};
  mash_top DUT (.SYS_CLK(clk), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
    .HREADYOUT(hready), .HRESP(hresp), .IRQ(irq), .LIMIT_CW(sens.limit_cw),
    .LIMIT_CCW(sens.limit_ccw), .NEAR_HOME(sens.near_home), .HOME(sens.home),
    .ZPHASE(sens.zphase), .ESTOP(estop), .MOT_STEP(step), .MOT_DIR(dir), .MOT_EXCITE(exc),
    .IF_SERIAL_EN(ser), .IF_USB_EN(usb), .IF_ETH_EN(eth), .BAUD_TICK(tick),
    .SER_CTS_N(cts_n), .RX_SPACE(room), .SER_RTS_N(rts_n), .TX_PERMIT(txp));
  mash_host_model u_host (.busy_host(busy_host), .ser_cts_n(cts_n), .rx_space(room));
  initial forever #12.5 clk = ~clk;
  // hang guard, well above the expected run of some 47k cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 95000) begin
      num_errors++;
      close_out();
    end
  end
  task automatic close_out;
    $display("errors %0d of %0d checks", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cmp(string what, logic [31:0] exp, logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // single ahb-lite transfer; read data taken at the data phase edge
  task automatic ahb(logic wr, logic [31:0] a, logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= a;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(logic [31:0] a, logic [31:0] d);
    ahb(1'b1, a, d, q);
    @(posedge clk); // written value settles before any pin is checked
  endtask
  task automatic rdc(string what, logic [31:0] a, logic [31:0] e);
    ahb(1'b0, a, 32'h0, q);
    cmp(what, e, q);
    cmp("response", 32'h0, hresp);
  endtask
  // set global, let cts pass its synchroniser, check link pins
  task automatic link(logic [31:0] g, logic b, logic [4:0] e);
    wr(REG_GLOBAL, g);
    busy_host <= b;
    repeat (4) @(posedge clk);
    cmp("link pins", e, {ser, usb, eth, txp, rts_n});
  endtask
  // home on z phase, count offset steps after origin is seen
  task automatic home(int x, logic [31:0] cfg, logic [31:0] off, int e);
    int s;
    s = 0;
    wr(REG_AXIS + 8 * x, cfg);
    wr(REG_AXIS + 8 * x + 4, off);
    wr(REG_CONTROL, 8 | x);
    do @(posedge clk); while (step[x] !== 1'b1);
    sens.zphase[x] <= 1'b1;
    repeat (4000) begin
      @(posedge clk);
      s += step[x];
    end
    sens.zphase[x] <= 1'b0;
    cmp("offset steps", e, s);
    ahb(1'b0, REG_STATUS, 32'h0, q);
    cmp("homed bit", 1, q[10 + x]);
    rdc("done event", REG_IRQ_STAT, 32'h1);
    wr(REG_IRQ_STAT, 32'h7);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rdc("register table", rows[i].a, rows[i].e);
    end
    // second reset in mid-run brings factory values back
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rdc("global default", REG_GLOBAL, 32'h0000000b);
    rdc("axis default", 8'h78, 32'h00481414);
    rdc("offset default", 8'h44, 32'h0);
    cmp("dir default", 8'hff, dir);
    // bit tick period for every rate
    for (int b = 0; b < 5; b++) begin
      wr(REG_GLOBAL, 32'h8 | b);
      do @(posedge clk); while (tick !== 1'b1);
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (tick !== 1'b1);
      cmp("bit period", divs[b], n);
    end
    link(32'h0b, 1'b1, 5'b10001);
    link(32'h0b, 1'b0, 5'b10010);
    link(32'h03, 1'b1, 5'b10010);
    link(32'h1b, 1'b0, 5'b01000);
    link(32'h2b, 1'b0, 5'b00100);
    // method 0: done at once, no homing, irq masked then raised then cleared
    wr(8'h58, 32'h00401414);
    wr(REG_CONTROL, 32'hb);
    rdc("none event", REG_IRQ_STAT, 32'h1);
    cmp("irq masked", 1'b0, irq);
    wr(REG_IRQ_MASK, 32'h7);
    cmp("irq raised", 1'b1, irq);
    ahb(1'b0, REG_STATUS, 32'h0, q);
    cmp("not homed", 1'b0, q[13]);
    wr(REG_IRQ_STAT, 32'h1);
    cmp("irq cleared", 1'b0, irq);
    // method 3 with no origin: reverse at cw limit, fail at ccw limit
    wr(8'h40, 32'h00581414);
    wr(REG_CONTROL, 32'h8);
    repeat (1000) @(posedge clk);
    cmp("start cw", 1'b1, dir[0]);
    sens.limit_cw[0] <= 1'b1;
    repeat (1000) @(posedge clk);
    cmp("reversed", 1'b0, dir[0]);
    sens.limit_cw[0] <= 1'b0;
    sens.limit_ccw[0] <= 1'b1;
    repeat (1000) @(posedge clk);
    sens.limit_ccw[0] <= 1'b0;
    rdc("fail event", REG_IRQ_STAT, 32'h2);
    wr(REG_IRQ_STAT, 32'h7);
    // method 4: near-home starts a cw creep, no origin, stop at cw limit
    wr(8'h60, 32'h00601414);
    wr(REG_CONTROL, 32'hc);
    sens.near_home[4] <= 1'b1;
    repeat (1000) @(posedge clk);
    sens.near_home[4] <= 1'b0;
    cmp("creep cw", 1'b1, dir[4]);
    sens.limit_cw[4] <= 1'b1;
    repeat (1000) @(posedge clk);
    sens.limit_cw[4] <= 1'b0;
    rdc("creep fail", REG_IRQ_STAT, 32'h2);
    wr(REG_IRQ_STAT, 32'h7);
    home(1, 32'h00680101, 32'h1, 1);
    home(2, 32'h0073e801, 32'h0, 5);
    // estop drops excitation only where hold is off
    wr(8'h50, 32'h00081414);
    wr(8'h68, 32'h004c1414);
    wr(REG_CONTROL, 32'ha);
    cmp("direction", 8'hdb, dir);
    estop <= 1'b1;
    repeat (8) @(posedge clk);
    cmp("excitation", 8'hfb, exc);
    rdc("estop event", REG_IRQ_STAT, 32'h6);
    estop <= 1'b0;
    // restore-defaults command brings factory axis values back
    wr(REG_CONTROL, 32'h20);
    rdc("restored", 8'h68, 32'h00481414);
    close_out();
  end
endmodule
bind mash_top mash_top_chk u_chk (.SYS_CLK(SYS_CLK), .RST(RST), .HSEL(HSEL), .HTRANS(HTRANS),
  .HWRITE(HWRITE), .HREADY(HREADY), .HRDATA(HRDATA), .ESTOP(ESTOP), .MOT_STEP(MOT_STEP),
  .MOT_EXCITE(MOT_EXCITE), .IF_SERIAL_EN(IF_SERIAL_EN), .IF_USB_EN(IF_USB_EN),
  .IF_ETH_EN(IF_ETH_EN), .BAUD_TICK(BAUD_TICK), .TX_PERMIT(TX_PERMIT));
